// >>> rtl/spi_read_host_regs.vh
`ifndef SPI_READ_HOST_REGS_VH
`define SPI_READ_HOST_REGS_VH

// Read opcodes, 3-byte and 4-byte address forms
`define OP_READ3 8'h03
`define OP_READ4 8'h13
`define OP_FAST3 8'h0B
`define OP_FAST4 8'h0C
`define OP_DOUT3 8'h3B
`define OP_DOUT4 8'h3C
`define OP_QOUT3 8'h6B
`define OP_QOUT4 8'h6C
`define OP_DIO3 8'hBB
`define OP_DIO4 8'hBC
`define OP_QIO3 8'hEB
`define OP_QIO4 8'hEC

// Read kinds
`define KIND_READ 3'h0
`define KIND_FAST 3'h1
`define KIND_DOUT 3'h2
`define KIND_QOUT 3'h3
`define KIND_DIO 3'h4
`define KIND_QIO 3'h5

// Latency codes
`define LC_00 2'h0
`define LC_01 2'h1
`define LC_10 2'h2
`define LC_11 2'h3

// Serial clock limit per latency code, kHz
`define LC_00_LIMIT_KHZ 80000
`define LC_01_LIMIT_KHZ 90000
`define LC_10_LIMIT_KHZ 104000
`define LC_11_LIMIT_KHZ 50000

// Mode and latency cycle counts
`define MODE_DIO 8'h04
`define MODE_QIO 8'h02
`define DUMMY_SINGLE_FAST 8'h08
`define DUMMY_SINGLE_LC11 8'h00
`define DUMMY_DIO_LC11 8'h00
`define DUMMY_DIO_LC00 8'h00
`define DUMMY_DIO_LC01 8'h01
`define DUMMY_DIO_LC10 8'h02
`define DUMMY_QIO_LC11 8'h01
`define DUMMY_QIO_LC00 8'h04
`define DUMMY_QIO_LC01 8'h04
`define DUMMY_QIO_LC10 8'h05

// Serial clock timing: core clock and core cycles per serial clock
`define CORE_CLK_KHZ 25000
`define SCK_DIV 4
`define SCK_KHZ (`CORE_CLK_KHZ / `SCK_DIV)

// Frame lengths: command in serial clocks, address in bits
`define CMD_CYCLES 8'h08
`define ADDR3_BITS 8'h18
`define ADDR4_BITS 8'h20

`endif

// >>> rtl/spi_read_host.v
// Contract
// - 03h plain read, 13h with 4-byte address
// - 0Bh fast read, 0Ch with 4-byte address
// - 3Bh dual-output read, 3Ch 4-byte form
// - 6Bh quad-output read, 6Ch 4-byte form
// - BBh dual-I/O read, BCh 4-byte form
// - EBh quad-I/O read, ECh 4-byte form
// - Code 11b: single/out reads no extra cycles
// - Code 11b: dual-I/O 4+0, quad-I/O 2+1
// - Code 00b: plain read unsupported, never issued
// - Codes 00b/01b: fast and out reads 8 dummies
// - Code 00b: dual-I/O 4+0, quad-I/O 2+4
// - Code 01b up to 90 MHz, no plain read
// - Code 01b: dual-I/O 4+1, quad-I/O 2+4
// - Code 10b valid up to 104 MHz
// - Code 10b: dual-I/O 4+2, quad-I/O 2+5
`timescale 1ns/1ps
`include "spi_read_host_regs.vh"

module spi_read_host (
  input wire core_clk_in,
  input wire rst_in,
  input wire start_in,
  input wire [2:0] kind_in,
  input wire addr4_in,
  input wire [31:0] addr_in,
  input wire [7:0] len_in,
  input wire [1:0] lat_code_in,
  input wire [3:0] io_in,
  output reg sck_out,
  output reg cs_n_out,
  output reg [3:0] io_out,
  output reg [3:0] io_oe_out,
  output reg busy_out,
  output reg refused_out,
  output reg [7:0] data_out,
  output reg data_valid_out,
  output reg done_out
);

  localparam ST_IDLE = 3'h0;
  localparam ST_CMD = 3'h1;
  localparam ST_ADDR = 3'h2;
  localparam ST_MODE = 3'h3;
  localparam ST_DUMMY = 3'h4;
  localparam ST_DATA = 3'h5;
  localparam ST_END = 3'h6;

  reg [2:0] state_q;
  reg [1:0] ph_q;
  reg [7:0] cnt_q;
  reg [2:0] w_q;
  reg [31:0] sh_q;
  reg [7:0] rx_q;
  reg [3:0] bits_q;
  reg [8:0] left_q;
  reg [2:0] kind_q;
  reg [1:0] code_q;
  reg [3:0] io_s1_q;
  reg [3:0] io_s2_q;
  reg [31:0] io_s_addr_q;
  reg addr4_q;

  function [7:0] opcode;
    input [2:0] k;
    input a4;
    begin
      case (k)
        `KIND_READ: opcode = a4 ? `OP_READ4 : `OP_READ3;
        `KIND_FAST: opcode = a4 ? `OP_FAST4 : `OP_FAST3;
        `KIND_DOUT: opcode = a4 ? `OP_DOUT4 : `OP_DOUT3;
        `KIND_QOUT: opcode = a4 ? `OP_QOUT4 : `OP_QOUT3;
        `KIND_DIO: opcode = a4 ? `OP_DIO4 : `OP_DIO3;
        default: opcode = a4 ? `OP_QIO4 : `OP_QIO3;
      endcase
    end
  endfunction

  function [7:0] mode_cyc;
    input [2:0] k;
    begin
      case (k)
        `KIND_DIO: mode_cyc = `MODE_DIO;
        `KIND_QIO: mode_cyc = `MODE_QIO;
        default: mode_cyc = 8'h00;
      endcase
    end
  endfunction

  function [7:0] dummy_cyc;
    input [2:0] k;
    input [1:0] c;
    begin
      case (k)
        `KIND_DIO: begin
          case (c)
            `LC_11: dummy_cyc = `DUMMY_DIO_LC11;
            `LC_00: dummy_cyc = `DUMMY_DIO_LC00;
            `LC_01: dummy_cyc = `DUMMY_DIO_LC01;
            default: dummy_cyc = `DUMMY_DIO_LC10;
          endcase
        end
        `KIND_QIO: begin
          case (c)
            `LC_11: dummy_cyc = `DUMMY_QIO_LC11;
            `LC_00: dummy_cyc = `DUMMY_QIO_LC00;
            `LC_01: dummy_cyc = `DUMMY_QIO_LC01;
            default: dummy_cyc = `DUMMY_QIO_LC10;
          endcase
        end
        default: begin
          if (c == `LC_11)
            dummy_cyc = `DUMMY_SINGLE_LC11;
          else
            dummy_cyc = `DUMMY_SINGLE_FAST;
        end
      endcase
    end
  endfunction

  function [2:0] addr_w;
    input [2:0] k;
    begin
      case (k)
        `KIND_DIO: addr_w = 3'h2;
        `KIND_QIO: addr_w = 3'h4;
        default: addr_w = 3'h1;
      endcase
    end
  endfunction

  function [2:0] data_w;
    input [2:0] k;
    begin
      case (k)
        `KIND_DOUT: data_w = 3'h2;
        `KIND_DIO: data_w = 3'h2;
        `KIND_QOUT: data_w = 3'h4;
        `KIND_QIO: data_w = 3'h4;
        default: data_w = 3'h1;
      endcase
    end
  endfunction

  // Serial clock is fixed, so the limit check is constant but kept explicit
  function code_ok;
    input [1:0] c;
    begin
      case (c)
        `LC_00: code_ok = (`SCK_KHZ <= `LC_00_LIMIT_KHZ);
        `LC_01: code_ok = (`SCK_KHZ <= `LC_01_LIMIT_KHZ);
        `LC_10: code_ok = (`SCK_KHZ <= `LC_10_LIMIT_KHZ);
        default: code_ok = (`SCK_KHZ <= `LC_11_LIMIT_KHZ);
      endcase
    end
  endfunction

  // Plain read only exists under code 11b
  wire start_ok = (kind_in <= `KIND_QIO) && code_ok(lat_code_in) &&
    ((kind_in != `KIND_READ) || (lat_code_in == `LC_11));

  wire quad_kind = (kind_q == `KIND_QOUT) || (kind_q == `KIND_QIO);
  wire [7:0] mode_n = mode_cyc(kind_q);
  wire [7:0] dummy_n = dummy_cyc(kind_q, code_q);
  wire drive_st = (state_q == ST_CMD) || (state_q == ST_ADDR) || (state_q == ST_MODE);
  wire bit_st = drive_st || (state_q == ST_DUMMY) || (state_q == ST_DATA);
  wire [3:0] bits_n = bits_q + {1'b0, w_q};
  wire [7:0] addr_cnt_bits = addr4_q ? `ADDR4_BITS : `ADDR3_BITS;
  wire [7:0] addr_cnt = (kind_q == `KIND_QIO) ? {2'b00, addr_cnt_bits[7:2]} :
    (kind_q == `KIND_DIO) ? {1'b0, addr_cnt_bits[7:1]} : addr_cnt_bits;

  reg [2:0] after_st;
  reg [7:0] after_cnt;
  reg [3:0] drv_io;
  reg [3:0] drv_oe;
  reg [7:0] rx_d;

  // Phase that follows address or mode cycles
  always @* begin
    if ((state_q == ST_ADDR) && (mode_n != 8'h00)) begin
      after_st = ST_MODE;
      after_cnt = mode_n;
    end else if (dummy_n != 8'h00) begin
      after_st = ST_DUMMY;
      after_cnt = dummy_n;
    end else begin
      after_st = ST_DATA;
      after_cnt = 8'h00;
    end
  end

  // WP and HOLD lines held high unless the read uses all four lines
  always @* begin
    drv_io = {~quad_kind, ~quad_kind, 2'b00};
    drv_oe = {~quad_kind, ~quad_kind, 2'b00};
    if (drive_st) begin
      case (w_q)
        3'h4: begin
          drv_io = sh_q[31:28];
          drv_oe = 4'hF;
        end
        3'h2: begin
          drv_io[1:0] = sh_q[31:30];
          drv_oe[1:0] = 2'h3;
        end
        default: begin
          drv_io[0] = sh_q[31];
          drv_oe[0] = 1'b1;
        end
      endcase
    end
  end

  always @* begin
    case (w_q)
      3'h4: rx_d = {rx_q[3:0], io_s2_q};
      3'h2: rx_d = {rx_q[5:0], io_s2_q[1:0]};
      default: rx_d = {rx_q[6:0], io_s2_q[1]};
    endcase
  end

  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      io_s1_q <= 4'h0;
      io_s2_q <= 4'h0;
    end else begin
      io_s1_q <= io_in;
      io_s2_q <= io_s1_q;
    end
  end

  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
      ph_q <= 2'h0;
      cnt_q <= 8'h00;
      w_q <= 3'h1;
      sh_q <= 32'h0000_0000;
      rx_q <= 8'h00;
      bits_q <= 4'h0;
      left_q <= 9'h000;
      kind_q <= 3'h0;
      code_q <= 2'h0;
      sck_out <= 1'b0;
      cs_n_out <= 1'b1;
      io_out <= 4'hC;
      io_oe_out <= 4'hC;
      busy_out <= 1'b0;
      refused_out <= 1'b0;
      data_out <= 8'h00;
      data_valid_out <= 1'b0;
      done_out <= 1'b0;
      io_s_addr_q <= 32'h0000_0000;
      addr4_q <= 1'b0;
    end else begin
      refused_out <= 1'b0;
      data_valid_out <= 1'b0;
      done_out <= 1'b0;
      io_out <= drv_io;
      io_oe_out <= drv_oe;
      ph_q <= (state_q == ST_IDLE) ? 2'h0 : ph_q + 2'h1;
      sck_out <= bit_st && (ph_q == 2'h1 || ph_q == 2'h2);
      if (bit_st && ph_q == 2'h3 && drive_st)
        sh_q <= sh_q << w_q;
      case (state_q)
        ST_IDLE: begin
          if (start_in) begin
            if (start_ok) begin
              state_q <= ST_CMD;
              cs_n_out <= 1'b0;
              busy_out <= 1'b1;
              kind_q <= kind_in;
              code_q <= lat_code_in;
              sh_q <= {opcode(kind_in, addr4_in), 24'h000000};
              cnt_q <= `CMD_CYCLES;
              w_q <= 3'h1;
              left_q <= {1'b0, len_in} + 9'h001;
              rx_q <= 8'h00;
              bits_q <= 4'h0;
              io_s_addr_q <= addr4_in ? addr_in : {addr_in[23:0], 8'h00};
              addr4_q <= addr4_in;
            end else begin
              refused_out <= 1'b1;
            end
          end
        end
        ST_CMD, ST_ADDR, ST_MODE, ST_DUMMY: begin
          if (ph_q == 2'h3) begin
            if (cnt_q != 8'h01) begin
              cnt_q <= cnt_q - 8'h01;
            end else if (state_q == ST_CMD) begin
              state_q <= ST_ADDR;
              w_q <= addr_w(kind_q);
              sh_q <= io_s_addr_q;
              cnt_q <= addr_cnt;
            end else if (state_q == ST_DUMMY || after_st == ST_DATA) begin
              state_q <= ST_DATA;
              w_q <= data_w(kind_q);
              bits_q <= 4'h0;
            end else begin
              // Mode bits sent as zero so the device never stays in continuous mode
              state_q <= after_st;
              cnt_q <= after_cnt;
              sh_q <= 32'h0000_0000;
            end
          end
        end
        ST_DATA: begin
          if (ph_q == 2'h3) begin
            rx_q <= rx_d;
            if (bits_n == 4'h8) begin
              bits_q <= 4'h0;
              data_out <= rx_d;
              data_valid_out <= 1'b1;
              left_q <= left_q - 9'h001;
              if (left_q == 9'h001) begin
                state_q <= ST_END;
                cs_n_out <= 1'b1;
              end
            end else begin
              bits_q <= bits_n;
            end
          end
        end
        ST_END: begin
          // Select stays high one serial period before the next frame
          if (ph_q == 2'h3) begin
            state_q <= ST_IDLE;
            busy_out <= 1'b0;
            done_out <= 1'b1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule

// >>> dv/flash_model.sv
`timescale 1ns/1ps
module flash_model (
  input wire sck_in,
  input wire cs_n_in,
  input wire [3:0] io_in,
  input wire [1:0] lat_code_in,
  output logic [3:0] dq_out,
  output logic [3:0] dq_oe_out,
  output logic [7:0] op_out,
  output logic [31:0] addr_out
);
  int n, k, ab, aw, w, st, j;
  logic [7:0] v;
  function automatic logic [7:0] pat(input int b);
    pat = 8'h5A + 8'h27 * b[7:0];
  endfunction
  // Unsupported reads get an FFh count, so data never starts
  function automatic int dum(input int k, input logic [1:0] c);
    case (k)
      0: dum = (c == 2'h3) ? 0 : 8'hFF;
      4: dum = (c == 2'h3) ? 0 : c;
      5: dum = (c == 2'h3) ? 1 : (c == 2'h2) ? 5 : 4;
      default: dum = (c == 2'h3) ? 0 : 8;
    endcase
  endfunction
  always @(negedge cs_n_in) begin
    n = 0;
    st = 9999;
    addr_out = 32'h0;
  end
  initial begin
    dq_oe_out = 4'h0;
    dq_out = 4'h0;
  end
  always @(posedge sck_in) if (!cs_n_in) begin
    if (n < 8) op_out = {op_out[6:0], io_in[0]};
    else if (n < 8 + ab / aw) addr_out = (addr_out << aw) | (io_in & ((1 << aw) - 1));
    n++;
    if (n == 8) begin
      case (op_out)
        8'h03, 8'h13: k = 0;
        8'h0B, 8'h0C: k = 1;
        8'h3B, 8'h3C: k = 2;
        8'h6B, 8'h6C: k = 3;
        8'hBB, 8'hBC: k = 4;
        default: k = 5;
      endcase
      ab = (op_out == 8'h13 || op_out[3:0] == 4'hC) ? 32 : 24;
      aw = (k == 4) ? 2 : (k == 5) ? 4 : 1;
      w = (k < 2) ? 1 : (k == 2 || k == 4) ? 2 : 4;
      st = 8 + ab / aw + ((k == 4) ? 4 : (k == 5) ? 2 : 0) +
        dum(k, lat_code_in);
    end
  end
  // Data launched on the falling serial edge; deselect wins a same-step tie
  always @(posedge cs_n_in or negedge sck_in) begin
    if (cs_n_in) begin
      dq_oe_out <= 4'h0;
    end else if (n >= st) begin
      j = n - st;
      v = pat(j / (8 / w)) >> (8 - w * (j % (8 / w) + 1));
      dq_oe_out <= (w == 1) ? 4'h2 : (w == 2) ? 4'h3 : 4'hF;
      dq_out <= (w == 1) ? {2'h0, v[0], 1'b0} : v[3:0];
    end
  end
endmodule

// >>> dv/spi_read_host_monitor.sv
`timescale 1ns/1ps
module spi_read_host_monitor (
  input wire core_clk_in,
  input wire rst_in,
  input wire start_in,
  input wire [2:0] kind_in,
  input wire [1:0] lat_code_in,
  input wire sck_out,
  input wire cs_n_out,
  input wire [3:0] io_oe_out,
  input wire busy_out,
  input wire refused_out,
  input wire data_valid_out,
  input wire done_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  wire take = start_in && !busy_out;
  a_plain_refused: assert property (
    take && kind_in == 3'h0 && lat_code_in != 2'h3 |-> ##[1:2] refused_out)
    else $error("plain read not refused");
  a_refused_idle: assert property (
    refused_out |-> cs_n_out && !busy_out)
    else $error("refused start opened a frame");
  a_accept_frame: assert property (
    take && kind_in inside {[3'h1:3'h5]} |-> ##[1:2] !cs_n_out && busy_out)
    else $error("read not started");
  a_bad_kind: assert property (
    take && kind_in[2:1] == 2'h3 |=> cs_n_out [*3])
    else $error("bad kind started a frame");
  a_sck_idle: assert property (
    cs_n_out |-> !sck_out)
    else $error("serial clock high while deselected");
  a_cmd_drive: assert property (
    $fell(cs_n_out) |=> io_oe_out[0] && !sck_out)
    else $error("command line not driven");
  a_done_after: assert property (
    done_out |-> cs_n_out && $past(cs_n_out, 3))
    else $error("done before deselect");
  a_done_pulse: assert property (
    done_out |=> !done_out)
    else $error("done longer than one cycle");
  a_valid_busy: assert property (
    data_valid_out |-> busy_out)
    else $error("data outside a read");
  a_sck_high: assert property (
    $rose(sck_out) |=> sck_out ##1 !sck_out)
    else $error("serial clock high time wrong");
endmodule

// >>> dv/spi_read_host_tb_top.sv
`timescale 1ns/1ps
module spi_read_host_tb_top;
  logic core_clk_in = 0, rst_in = 1, start_in = 0, addr4_in = 0, flip = 0;
  logic [2:0] kind_in = 3'h0;
  logic [31:0] addr_in = 32'h12345678;
  logic [7:0] len_in = 8'h02;
  logic [1:0] lat_code_in = 2'h3;
  wire sck_out, cs_n_out, busy_out, refused_out, data_valid_out, done_out;
  wire [3:0] io_out, io_oe_out, dq, dq_oe, io_w;
  wire [7:0] data_out, m_op;
  wire [31:0] m_addr;
  int n_fail = 0, comparisons = 0;
  logic [15:0] rows [16] = '{16'h0303, 16'h0713, 16'h080B, 16'h0D0C, 16'h123B, 16'h173C,
    16'h186B, 16'h1E6C, 16'h23BB, 16'h24BC, 16'h21BB, 16'h26BC, 16'h2BEB, 16'h2CEC,
    16'h29EB, 16'h2EEC};
  always #20 core_clk_in = ~core_clk_in;
  // Released lines toggle so a stale level is never read back
  always @(negedge core_clk_in) flip <= ~flip;
  assign io_w = (io_oe_out & io_out) | (~io_oe_out & dq_oe & dq) |
    (~io_oe_out & ~dq_oe & {4{flip}});
  spi_read_host spi_read_host_i (.core_clk_in(core_clk_in), .rst_in(rst_in), .start_in(start_in),
    .kind_in(kind_in), .addr4_in(addr4_in), .addr_in(addr_in), .len_in(len_in),
    .lat_code_in(lat_code_in), .io_in(io_w), .sck_out(sck_out), .cs_n_out(cs_n_out),
    .io_out(io_out), .io_oe_out(io_oe_out), .busy_out(busy_out), .refused_out(refused_out),
    .data_out(data_out), .data_valid_out(data_valid_out), .done_out(done_out));
  flash_model flash_model_i (.sck_in(sck_out), .cs_n_in(cs_n_out), .io_in(io_w),
    .lat_code_in(lat_code_in), .dq_out(dq), .dq_oe_out(dq_oe), .op_out(m_op), .addr_out(m_addr));
  function automatic logic [7:0] pat(input int b);
    pat = 8'h5A + 8'h27 * b[7:0];
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("n_fail %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task run(input logic [2:0] k, input logic a, input logic [1:0] c, input logic [7:0] op);
    int i, b;
    @(negedge core_clk_in);
    kind_in = k;
    addr4_in = a;
    lat_code_in = c;
    start_in = 1;
    @(negedge core_clk_in);
    start_in = 0;
    b = 0;
    for (i = 0; i < 3000 && done_out !== 1'b1; i++) begin
      @(posedge core_clk_in);
      #1;
      if (data_valid_out === 1'b1) begin
        chk(data_out, pat(b));
        b++;
      end
    end
    chk(b, len_in + 1);
    chk(m_op, op);
    chk(m_addr, a ? 32'h12345678 : 32'h00345678);
  endtask
  // Refusal may land on any of the four edges after the take
  task refuse(input logic [2:0] k, input logic [1:0] c);
    int r;
    r = 0;
    @(negedge core_clk_in);
    kind_in = k;
    lat_code_in = c;
    start_in = 1;
    repeat (4) begin
      @(posedge core_clk_in);
      #1;
      r += (refused_out === 1'b1) + 2 * (cs_n_out !== 1'b1);
      @(negedge core_clk_in);
      start_in = 0;
    end
    chk(r, 1);
  endtask
  initial begin
    #(40 * 20000);
    n_fail++;
    complete_run;
  end
  initial begin
    repeat (3) @(negedge core_clk_in);
    chk({sck_out, cs_n_out, io_out, io_oe_out, busy_out, done_out}, 12'h730);
    repeat (2) @(negedge core_clk_in);
    rst_in = 0;
    foreach (rows[r]) run(rows[r][13:11], rows[r][10], rows[r][9:8], rows[r][7:0]);
    for (int c = 0; c < 3; c++) refuse(3'h0, c[1:0]);
    refuse(3'h6, 2'h3);
    refuse(3'h7, 2'h3);
    len_in = 8'hFF;
    run(3'h5, 1'b0, 2'h2, 8'hEB);
    len_in = 8'h00;
    run(3'h0, 1'b1, 2'h3, 8'h13);
    @(negedge core_clk_in);
    kind_in = 3'h1;
    start_in = 1;
    @(negedge core_clk_in);
    start_in = 0;
    repeat (60) @(negedge core_clk_in);
    rst_in = 1;
    @(negedge core_clk_in);
    chk({sck_out, cs_n_out, io_out, io_oe_out, busy_out, done_out}, 12'h730);
    rst_in = 0;
    run(3'h1, 1'b0, 2'h1, 8'h0B);
    complete_run;
  end
endmodule
bind spi_read_host spi_read_host_monitor spi_read_host_monitor_i (.core_clk_in(core_clk_in),
  .rst_in(rst_in), .start_in(start_in), .kind_in(kind_in), .lat_code_in(lat_code_in),
  .sck_out(sck_out), .cs_n_out(cs_n_out), .io_oe_out(io_oe_out), .busy_out(busy_out),
  .refused_out(refused_out), .data_valid_out(data_valid_out), .done_out(done_out));
